// [design/sld_settle_timer.v]
/*
  Settling-delay timer: flag high while the count runs after a start pulse.
  Assumes a start pulse on the same clock.
*/
`timescale 1ns/10ps

module sld_settle_timer #(
  parameter CNT_W = 15,
  parameter [CNT_W-1:0] CYCLES = 15'd15000
) (
  input  wire i_mclk,
  input  wire i_nrst,
  input  wire i_ce,
  input  wire i_start,
  output wire o_busy
);

  reg [CNT_W-1:0] cnt_reg;

  // ----------------------------------------
  // Down counter
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else if (i_ce) begin
      if (i_start) begin
        cnt_reg <= CYCLES;
      end else if (cnt_reg != {CNT_W{1'b0}}) begin
        cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign o_busy = (cnt_reg != {CNT_W{1'b0}});

endmodule

// [design/sld_top.v]
/*
  Supervisor low-power state decoder with hazard detector, Avalon-MM slave,
  settling flags and a masked level interrupt.
  Assumes a software master on i_mclk; power mode is written by software.
*/
`timescale 1ns/10ps
`include "sld_defs.vh"

module sld_top #(
  parameter SETTLE_CYCLES = `SLD_SETTLE_CYC
) (
  input  wire        i_mclk,
  input  wire        i_nrst,
  input  wire        i_ce,
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  output reg  [1:0]  o_low_sup_state,
  output reg  [1:0]  o_low_mon_state,
  output reg  [1:0]  o_high_sup_state,
  output reg  [1:0]  o_high_mon_state,
  output reg         o_fast_wake,
  output reg         o_hazard,
  output reg         o_wake_hang_risk,
  output reg         o_low_settle_flag,
  output reg         o_high_settle_flag,
  output reg         o_irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [`SLD_CTRL_W-1:0] low_side_control_reg;
  reg [`SLD_CTRL_W-1:0] high_side_control_reg;
  reg                   mode_reg;
  reg [`SLD_FLG_W-1:0]  power_flag_reg;
  reg [`SLD_FLG_W-1:0]  mask_reg;
  reg                   ack_reg;
  reg                   hazard_d_reg;
  reg                   low_settle_d_reg;
  reg                   high_settle_d_reg;
  reg [7:0]             hang_cnt_reg;

  localparam [7:0] HANG_CYC = `SLD_HANG_CYC;

  wire       acc       = (i_avs_read | i_avs_write) & ~ack_reg;
  wire       wr        = i_avs_write & ~ack_reg & i_ce;
  wire       wr_low    = wr & (i_avs_address == `SLD_LOW_CTRL_OFS);
  wire       wr_high   = wr & (i_avs_address == `SLD_HIGH_CTRL_OFS);
  wire       wr_mode   = wr & (i_avs_address == `SLD_MODE_OFS);
  wire       wr_flag   = wr & (i_avs_address == `SLD_FLAG_OFS);
  wire       wr_mask   = wr & (i_avs_address == `SLD_MASK_OFS);
  wire       deep      = mode_reg;

  // ----------------------------------------
  // Unit decoders
  // ----------------------------------------
  wire [1:0] low_sup_st;
  wire [1:0] low_mon_st;
  wire [1:0] high_sup_st;
  wire [1:0] high_mon_st;

  sld_unit_decode u_low_sup (
    .i_enable    (low_side_control_reg[`SLD_SUP_EN_BIT]),
    .i_keep      (low_side_control_reg[`SLD_SUP_KEEP_BIT]),
    .i_full_perf (low_side_control_reg[`SLD_SUP_FP_BIT]),
    .i_auto      (low_side_control_reg[`SLD_AUTO_BIT]),
    .i_deep      (deep),
    .o_state     (low_sup_st)
  );

  sld_unit_decode u_low_mon (
    .i_enable    (low_side_control_reg[`SLD_MON_EN_BIT]),
    .i_keep      (1'b1),
    .i_full_perf (low_side_control_reg[`SLD_MON_FP_BIT]),
    .i_auto      (low_side_control_reg[`SLD_AUTO_BIT]),
    .i_deep      (deep),
    .o_state     (low_mon_st)
  );

  sld_unit_decode u_high_sup (
    .i_enable    (high_side_control_reg[`SLD_SUP_EN_BIT]),
    .i_keep      (high_side_control_reg[`SLD_SUP_KEEP_BIT]),
    .i_full_perf (high_side_control_reg[`SLD_SUP_FP_BIT]),
    .i_auto      (high_side_control_reg[`SLD_AUTO_BIT]),
    .i_deep      (deep),
    .o_state     (high_sup_st)
  );

  sld_unit_decode u_high_mon (
    .i_enable    (high_side_control_reg[`SLD_MON_EN_BIT]),
    .i_keep      (1'b1),
    .i_full_perf (high_side_control_reg[`SLD_MON_FP_BIT]),
    .i_auto      (high_side_control_reg[`SLD_AUTO_BIT]),
    .i_deep      (deep),
    .o_state     (high_mon_st)
  );

  // ----------------------------------------
  // Wake time and hazard detector
  // ----------------------------------------
  wire l_se  = low_side_control_reg[`SLD_SUP_EN_BIT];
  wire l_sfp = low_side_control_reg[`SLD_SUP_FP_BIT];
  wire l_me  = low_side_control_reg[`SLD_MON_EN_BIT];
  wire l_mfp = low_side_control_reg[`SLD_MON_FP_BIT];
  wire h_se  = high_side_control_reg[`SLD_SUP_EN_BIT];
  wire h_sk  = high_side_control_reg[`SLD_SUP_KEEP_BIT];
  wire h_sfp = high_side_control_reg[`SLD_SUP_FP_BIT];
  wire h_me  = high_side_control_reg[`SLD_MON_EN_BIT];
  wire h_mfp = high_side_control_reg[`SLD_MON_FP_BIT];
  wire h_au  = high_side_control_reg[`SLD_AUTO_BIT];

  wire fast_wake    = ~l_se | l_sfp;
  wire low_exposed  = ~l_se | (l_se & l_sfp) | ~l_me | (l_me & l_mfp);
  wire high_sup_hit = h_se & ~h_sfp & (~h_sk | (h_sk & h_au));
  wire high_mon_hit = h_me & ~h_mfp & h_au;
  wire hazard       = low_exposed & (high_sup_hit | high_mon_hit);

  // ----------------------------------------
  // Settling-delay timers
  // ----------------------------------------
  wire low_busy;
  wire high_busy;

  sld_settle_timer #(
    .CNT_W  (15),
    .CYCLES (SETTLE_CYCLES[14:0])
  ) u_low_settle (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_start (wr_low),
    .o_busy  (low_busy)
  );

  sld_settle_timer #(
    .CNT_W  (15),
    .CYCLES (SETTLE_CYCLES[14:0])
  ) u_high_settle (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_start (wr_high),
    .o_busy  (high_busy)
  );

  // ----------------------------------------
  // Events: settle done, hazard rise
  // ----------------------------------------
  wire [`SLD_FLG_W-1:0] evt;
  assign evt[`SLD_FLG_LOW_SET]  = low_settle_d_reg & ~low_busy;
  assign evt[`SLD_FLG_HIGH_SET] = high_settle_d_reg & ~high_busy;
  assign evt[`SLD_FLG_HAZARD]   = hazard & ~hazard_d_reg;

  // Deep entry while affected or not settled: hang window counter
  wire deep_entry = wr_mode & i_avs_writedata[`SLD_MODE_DEEP_BIT] & ~mode_reg;
  wire risky      = hazard | low_busy | high_busy;

  // ----------------------------------------
  // Register file and bus
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      low_side_control_reg  <= `SLD_CTRL_RST;
      high_side_control_reg <= `SLD_CTRL_RST;
      mode_reg              <= `SLD_MODE_RST;
      power_flag_reg        <= `SLD_FLAG_RST;
      mask_reg              <= `SLD_MASK_RST;
      ack_reg               <= 1'b0;
      o_avs_readdata        <= 32'h0000_0000;
      o_avs_waitrequest     <= 1'b1;
    end else if (i_ce) begin
      ack_reg           <= acc;
      o_avs_waitrequest <= ~acc;
      if (wr_low) begin
        low_side_control_reg <= i_avs_writedata[`SLD_CTRL_W-1:0];
      end
      if (wr_high) begin
        high_side_control_reg <= i_avs_writedata[`SLD_CTRL_W-1:0];
      end
      if (wr_mode) begin
        mode_reg <= i_avs_writedata[`SLD_MODE_DEEP_BIT];
      end
      if (wr_mask) begin
        mask_reg <= i_avs_writedata[`SLD_FLG_W-1:0];
      end
      if (wr_flag) begin
        power_flag_reg <= (power_flag_reg & ~i_avs_writedata[`SLD_FLG_W-1:0]) | evt;
      end else begin
        power_flag_reg <= power_flag_reg | evt;
      end
      o_avs_readdata <= 32'h0000_0000;
      if (i_avs_read & ~ack_reg) begin
        case (i_avs_address)
          `SLD_LOW_CTRL_OFS:  o_avs_readdata <= {26'h0, low_side_control_reg};
          `SLD_HIGH_CTRL_OFS: o_avs_readdata <= {26'h0, high_side_control_reg};
          `SLD_MODE_OFS:      o_avs_readdata <= {31'h0, mode_reg};
          `SLD_STATE_OFS:     o_avs_readdata <= {20'h0, low_busy, high_busy, fast_wake, hazard,
                                                 high_mon_st, high_sup_st, low_mon_st, low_sup_st};
          `SLD_FLAG_OFS:      o_avs_readdata <= {29'h0, power_flag_reg};
          `SLD_MASK_OFS:      o_avs_readdata <= {29'h0, mask_reg};
          default:            o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_low_sup_state    <= `SLD_ST_OFF;
      o_low_mon_state    <= `SLD_ST_OFF;
      o_high_sup_state   <= `SLD_ST_OFF;
      o_high_mon_state   <= `SLD_ST_OFF;
      o_fast_wake        <= 1'b0;
      o_hazard           <= 1'b0;
      o_wake_hang_risk   <= 1'b0;
      o_low_settle_flag  <= 1'b0;
      o_high_settle_flag <= 1'b0;
      o_irq              <= 1'b0;
      hazard_d_reg       <= 1'b0;
      low_settle_d_reg   <= 1'b0;
      high_settle_d_reg  <= 1'b0;
      hang_cnt_reg       <= 8'h00;
    end else if (i_ce) begin
      o_low_sup_state    <= low_sup_st;
      o_low_mon_state    <= low_mon_st;
      o_high_sup_state   <= high_sup_st;
      o_high_mon_state   <= high_mon_st;
      o_fast_wake        <= fast_wake;
      o_hazard           <= hazard;
      o_low_settle_flag  <= low_busy;
      o_high_settle_flag <= high_busy;
      o_irq              <= |(power_flag_reg & mask_reg);
      hazard_d_reg       <= hazard;
      low_settle_d_reg   <= low_busy;
      high_settle_d_reg  <= high_busy;
      if (deep_entry & risky) begin
        hang_cnt_reg <= HANG_CYC;
      end else if (hang_cnt_reg != 8'h00) begin
        hang_cnt_reg <= hang_cnt_reg - 8'h01;
      end
      o_wake_hang_risk <= (deep_entry & risky) | (hang_cnt_reg > 8'h01);
    end
  end

endmodule

// [design/sld_unit_decode.v]
/*
  State decode of one supervisor or monitor unit.
  Assumes control bits from registers on the same clock; purely combinational.
*/
`timescale 1ns/10ps
`include "sld_defs.vh"

module sld_unit_decode (
  input  wire       i_enable,
  input  wire       i_keep,
  input  wire       i_full_perf,
  input  wire       i_auto,
  input  wire       i_deep,
  output reg  [1:0] o_state
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always @* begin
    o_state = `SLD_ST_OFF;
    if (i_enable) begin
      if (!i_deep) begin
        o_state = i_full_perf ? `SLD_ST_FULL : `SLD_ST_NORMAL;
      end else if (i_keep) begin
        if (i_auto) begin
          o_state = i_full_perf ? `SLD_ST_NORMAL : `SLD_ST_OFF;
        end else begin
          o_state = i_full_perf ? `SLD_ST_FULL : `SLD_ST_NORMAL;
        end
      end
    end
  end

endmodule

// [inc/sld_defs.vh]
/*
  Constants for the supervisor low-power state decoder: register offsets,
  field positions, reset values, state codes and timing counts.
  Assumes inclusion by bare name from design files.
*/
`ifndef SLD_DEFS_VH
`define SLD_DEFS_VH

// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define SLD_LOW_CTRL_OFS   4'h0
`define SLD_HIGH_CTRL_OFS  4'h1
`define SLD_MODE_OFS       4'h2
`define SLD_STATE_OFS      4'h3
`define SLD_FLAG_OFS       4'h4
`define SLD_MASK_OFS       4'h5

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define SLD_SUP_EN_BIT     0
`define SLD_SUP_KEEP_BIT   1
`define SLD_SUP_FP_BIT     2
`define SLD_MON_EN_BIT     3
`define SLD_MON_FP_BIT     4
`define SLD_AUTO_BIT       5
`define SLD_CTRL_W         6

// ----------------------------------------
// Power mode field: 0 active/light, 1 deep
// ----------------------------------------
`define SLD_MODE_DEEP_BIT  0

// ----------------------------------------
// Flag and mask bit positions
// ----------------------------------------
`define SLD_FLG_LOW_SET    0
`define SLD_FLG_HIGH_SET   1
`define SLD_FLG_HAZARD     2
`define SLD_FLG_W          3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SLD_CTRL_RST       6'h00
`define SLD_MODE_RST       1'h0
`define SLD_FLAG_RST       3'h0
`define SLD_MASK_RST       3'h0

// ----------------------------------------
// Unit state codes
// ----------------------------------------
`define SLD_ST_OFF         2'h0
`define SLD_ST_NORMAL      2'h1
`define SLD_ST_FULL        2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define SLD_CLK_MHZ        100
`define SLD_SETTLE_US      150
`define SLD_SETTLE_CYC     (`SLD_SETTLE_US * `SLD_CLK_MHZ)
`define SLD_HANG_US        1
`define SLD_HANG_CYC       (`SLD_HANG_US * `SLD_CLK_MHZ)

`endif

// [sim/sld_top_sva.sv]
/*
  Port assertions for sld_top.
  Assumes a bind from the bench, i_ce held high and one clock.
*/
`timescale 1ns/10ps
module sld_top_sva #(
  parameter SETTLE_CYCLES = 15000
) (
  input wire        i_mclk,
  input wire        i_nrst,
  input wire        i_ce,
  input wire [3:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire [1:0]  o_low_sup_state,
  input wire [1:0]  o_low_mon_state,
  input wire [1:0]  o_high_sup_state,
  input wire [1:0]  o_high_mon_state,
  input wire        o_fast_wake,
  input wire        o_hazard,
  input wire        o_wake_hang_risk,
  input wire        o_low_settle_flag,
  input wire        o_high_settle_flag,
  input wire        o_irq
);
  // ----------------
  // Mode shadow
  // ----------------
  logic        deep_reg;
  logic        deep_d_reg;
  logic [15:0] cnt_reg;
  wire take = i_ce && o_avs_waitrequest && (i_avs_read || i_avs_write);
  wire act  = !deep_reg && !deep_d_reg;
  wire lowr = take && i_avs_write && i_avs_address == 4'h0;
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      deep_reg   <= 1'b0;
      deep_d_reg <= 1'b1;
      cnt_reg    <= 16'h0;
    end else begin
      if (take && i_avs_write && i_avs_address == 4'h2) deep_reg <= i_avs_writedata[0];
      deep_d_reg <= deep_reg;
      cnt_reg    <= (o_low_settle_flag && !lowr) ? cnt_reg + 16'h1 : 16'h0;
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_wr(a);
    take && i_avs_write && i_avs_address == a;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_bus_answer: assert property (take |=> s_answer) else $error("bus answer late");
  a_rdata_idle: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0) else $error("stray read data");
  a_state_code: assert property (o_low_sup_state != 2'h3 && o_low_mon_state != 2'h3 &&
                                 o_high_sup_state != 2'h3 && o_high_mon_state != 2'h3)
    else $error("bad state code");
  a_fast_wake: assert property (act |-> o_fast_wake == (o_low_sup_state != 2'h1)) else $error("wake speed");
  a_hazard_low: assert property (act && o_hazard |-> o_low_sup_state != 2'h1 || o_low_mon_state != 2'h1)
    else $error("hazard without exposure");
  a_hazard_high: assert property (act && o_hazard |-> o_high_sup_state == 2'h1 || o_high_mon_state == 2'h1)
    else $error("hazard without high unit");
  a_low_settle: assert property (s_wr(4'h0) |-> ##[1:3] o_low_settle_flag) else $error("low settle missing");
  a_high_settle: assert property (s_wr(4'h1) |-> ##[1:3] o_high_settle_flag) else $error("high settle missing");
  a_settle_bound: assert property (cnt_reg < SETTLE_CYCLES + 4) else $error("settle too long");
endmodule

// [sim/sld_top_tb_top.sv]
/*
  Self-checking bench for sld_top over its Avalon-MM port.
  Assumes SETTLE_CYCLES of 20 and i_ce held high.
*/
`timescale 1ns/10ps
module sld_top_tb_top;
  logic        i_mclk, i_nrst, i_ce, i_avs_read, i_avs_write;
  logic [3:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q, e;
  logic [1:0]  o_low_sup_state, o_low_mon_state, o_high_sup_state, o_high_mon_state;
  logic        o_avs_waitrequest, o_fast_wake, o_hazard, o_wake_hang_risk;
  logic        o_low_settle_flag, o_high_settle_flag, o_irq;
  int          err_count, checked, n, hcnt;

  sld_top #(.SETTLE_CYCLES(20)) DUT (.*);

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  always @(negedge i_mclk) if (o_wake_hang_risk === 1'b1) hcnt++;

  // ----------------
  // Helpers
  // ----------------
  task tally_and_finish;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input [31:0] g, input [31:0] x);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge i_mclk);
    i_avs_write     <= w;
    i_avs_read      <= !w;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge i_mclk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      err_count++;
      tally_and_finish();
    end
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask

  task settle;
    repeat (3) @(negedge i_mclk);
    for (n = 0; n < 200; n++) begin
      @(negedge i_mclk);
      if (o_low_settle_flag === 1'b0 && o_high_settle_flag === 1'b0) break;
    end
    if (n == 200) begin
      err_count++;
      tally_and_finish();
    end
  endtask

  function [1:0] st(input en, k, f, a, d);
    if (!en) st = 2'h0;
    else if (!d) st = f ? 2'h2 : 2'h1;
    else if (a) st = (k && f) ? 2'h1 : 2'h0;
    else st = k ? (f ? 2'h2 : 2'h1) : 2'h0;
  endfunction

  function [31:0] stat(input [5:0] l, input [5:0] h, input d);
    logic x;
    x = !l[0] || l[2] || !l[3] || l[4];
    stat = {22'h0, !l[0] || l[2], x && ((h[0] && !h[2] && (!h[1] || h[5])) || (h[3] && !h[4] && h[5])),
            st(h[3], 1'b1, h[4], h[5], d), st(h[0], h[1], h[2], h[5], d),
            st(l[3], 1'b1, l[4], l[5], d), st(l[0], l[1], l[2], l[5], d)};
  endfunction

  // ----------------
  // Scenarios
  // ----------------
  task t_bus;
    bus(1, 4'h3, 32'hffffffff);
    bus(0, 4'h3, 32'h0);
    chk(q, 32'h200);
    bus(1, 4'h9, 32'hffffffff);
    bus(0, 4'h9, 32'h0);
    chk(q, 32'h0);
    bus(1, 4'h5, 32'hffffffff);
    bus(0, 4'h5, 32'h0);
    chk(q, 32'h7);
    bus(1, 4'h5, 32'h0);
  endtask

  task t_decode;
    for (int i = 0; i < 4096; i++) begin
      bus(1, 4'h0, {26'h0, i[5:0]});
      bus(1, 4'h1, {26'h0, i[11:6]});
      bus(1, 4'h2, {31'h0, i[0] ^ i[6]});
      bus(0, 4'h3, 32'h0);
      e = stat(i[5:0], i[11:6], i[0] ^ i[6]);
      chk(q & 32'h3ff, e);
      chk(o_hazard, e[8]);
    end
  endtask

  task t_irq;
    bus(1, 4'h2, 32'h0);
    bus(1, 4'h0, 32'h9);
    bus(1, 4'h1, 32'h0);
    settle();
    bus(1, 4'h4, 32'h7);
    bus(1, 4'h5, 32'h1);
    @(negedge i_mclk);
    chk(o_irq, 1'b0);
    bus(1, 4'h0, 32'h9);
    settle();
    bus(0, 4'h4, 32'h0);
    chk(q, 32'h1);
    @(negedge i_mclk);
    chk(o_irq, 1'b1);
    bus(1, 4'h5, 32'h0);
    @(negedge i_mclk);
    chk(o_irq, 1'b0);
    bus(1, 4'h5, 32'h1);
    @(negedge i_mclk);
    chk(o_irq, 1'b1);
    bus(1, 4'h4, 32'h1);
    @(negedge i_mclk);
    chk(o_irq, 1'b0);
    bus(1, 4'h1, 32'h1);
    bus(1, 4'h0, 32'h0);
    settle();
    bus(0, 4'h4, 32'h0);
    chk(q, 32'h7);
    bus(1, 4'h4, 32'h7);
  endtask

  task t_hang;
    hcnt = 0;
    bus(1, 4'h2, 32'h1);
    repeat (200) @(negedge i_mclk);
    chk(hcnt, 32'd100);
    bus(1, 4'h2, 32'h0);
    bus(1, 4'h1, 32'h3);
    settle();
    hcnt = 0;
    bus(1, 4'h2, 32'h1);
    repeat (200) @(negedge i_mclk);
    chk(hcnt, 32'd0);
  endtask

  initial begin
    i_nrst          = 1'b0;
    i_ce            = 1'b1;
    i_avs_read      = 1'b0;
    i_avs_write     = 1'b0;
    i_avs_address   = 4'h0;
    i_avs_writedata = 32'h0;
    err_count       = 0;
    checked         = 0;
    hcnt            = 0;
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_bus();
    t_decode();
    t_irq();
    t_hang();
    tally_and_finish();
  end
endmodule

bind sld_top sld_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (.*);
